// ==== src/pbus_pkg.sv ====
// Package with the constants shared by the peripheral byte bus port.
`default_nettype none
package pbus_pkg;
   // =====================================================================
   // Widths and status layout
   // =====================================================================
   localparam int unsigned BUS_W = 8;
   localparam int unsigned BUSY_STATUS_BIT = 4;
   localparam logic [7:0] STATUS_RST = 8'h00;
   // =====================================================================
   // Timing
   // =====================================================================
   localparam int unsigned CLK_PERIOD_NS = 5;
   localparam int unsigned ACK_PULSE_NS = 100;
   localparam int unsigned ACK_PULSE_CYC = (ACK_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned READ_STROBE_NS = 50;
   localparam int unsigned READ_STROBE_CYC = (READ_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned STATUS_STROBE_NS = 50;
   localparam int unsigned STATUS_STROBE_CYC = (STATUS_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CNT_W = 8;
endpackage
`default_nettype wire

// ==== src/pbus_stream_if.sv ====
// Interface carrying accepted bytes from the pin front end to the port core.
`default_nettype none
interface pbus_stream_if;
   logic valid;
   logic [7:0] data;
   modport src (output valid, output data);
   modport dst (input valid, input data);
endinterface
`default_nettype wire

// ==== src/pbus_write_capture.sv ====
// Synchronises the write strobe and bus pins and captures a byte on the strobe's rise.
`default_nettype none
module pbus_write_capture
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Pins
   input wire logic write_strobe_n,
   input wire logic [7:0] bus_in,
   // Captured bytes
   pbus_stream_if.src wr
);
   logic [1:0] strb_sync_ff;
   logic strb_prev_ff;
   logic [7:0] bus_s1_ff;
   logic [7:0] bus_s2_ff;
   logic valid_ff;
   logic [7:0] data_ff;
   wire rise = strb_sync_ff[1] & ~strb_prev_ff;

   // Two-stage synchronisers; only stage two feeds the edge detector.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         strb_sync_ff <= 2'h3;
         strb_prev_ff <= 1'b1;
         bus_s1_ff <= 8'h00;
         bus_s2_ff <= 8'h00;
      end
      else
      begin
         strb_sync_ff <= {strb_sync_ff[0], write_strobe_n};
         strb_prev_ff <= strb_sync_ff[1];
         bus_s1_ff <= bus_in;
         bus_s2_ff <= bus_s1_ff;
      end
   end

   // The bus byte is taken on the rising edge; the writer holds data across it.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         valid_ff <= 1'b0;
         data_ff <= 8'h00;
      end
      else
      begin
         valid_ff <= rise;
         if (rise)
            data_ff <= bus_s2_ff;
      end
   end

   assign wr.valid = valid_ff;
   assign wr.data = data_ff;
endmodule
`default_nettype wire

// ==== src/periph_byte_bus_port.sv ====
// Peripheral byte bus port: write capture, read strobing, status strobing and busy handshake.
`default_nettype none
// Operation
// - Byte-wide two-way bus carries data in and status out.
// - While read strobe is low, peripheral drives byte and device takes it.
// - Status byte is driven only while the status strobe is low.
// - Status strobe fires only on fresh status, never for an unchanged byte.
// - Bus byte is captured on the rising edge of the write strobe.
// - Busy is high while processing the last byte, low when ready again.
// - Busy pulses high for a short time after every write.
// - A write that fills the buffer holds busy high until space frees.
// - Busy state is mirrored into the status busy bit.
module periph_byte_bus_port
#(
   parameter int unsigned ACK_CYC = pbus_pkg::ACK_PULSE_CYC,
   parameter int unsigned RD_CYC = pbus_pkg::READ_STROBE_CYC,
   parameter int unsigned STS_CYC = pbus_pkg::STATUS_STROBE_CYC
)
(
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // Peripheral bus pins
   input wire logic [7:0] periph_byte_bus_in,
   output logic [7:0] periph_byte_bus_out,
   output logic periph_byte_bus_oe,
   output logic status_strobe_n,
   output logic periph_read_strobe_n,
   input wire logic periph_write_strobe_n,
   output logic busy_n_pin,
   // Core side: received bytes
   output logic rx_valid,
   output logic [7:0] rx_data,
   output logic rx_from_read,
   input wire logic buffer_full,
   // Core side: read request and status source
   input wire logic read_req,
   input wire logic [7:0] status_in
);
   // =====================================================================
   // Parameter checks and reset release
   // =====================================================================
   if (ACK_CYC < 1 || ACK_CYC > 255 || RD_CYC < 2 || RD_CYC > 255 || STS_CYC < 1 || STS_CYC > 255)
      $error("periph_byte_bus_port: strobe or pulse counts out of range");

   logic [1:0] rst_sync_ff;
   wire rst_n = rst_sync_ff[1];
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         rst_sync_ff <= 2'h0;
      else
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
   end

   // =====================================================================
   // Write path
   // =====================================================================
   pbus_stream_if wr_if ();
   pbus_write_capture u_cap
   (
      .clk(mclk),
      .rst_n(rst_n),
      .write_strobe_n(periph_write_strobe_n),
      .bus_in(periph_byte_bus_in),
      .wr(wr_if.src)
   );

   // Bus input and write strobe resynchronised; the arbiter must never read a raw pin.
   logic [7:0] bus_s1_ff;
   logic [7:0] bus_s2_ff;
   logic [1:0] wstrb_sync_ff;
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         bus_s1_ff <= 8'h00;
         bus_s2_ff <= 8'h00;
         wstrb_sync_ff <= 2'h3;
      end
      else
      begin
         bus_s1_ff <= periph_byte_bus_in;
         bus_s2_ff <= bus_s1_ff;
         wstrb_sync_ff <= {wstrb_sync_ff[0], periph_write_strobe_n};
      end
   end

   // =====================================================================
   // Bus owner state machine
   // =====================================================================
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b001,
      ST_READ = 3'b010,
      ST_STAT = 3'b100
   } bus_state_t;

   bus_state_t state_ff;
   bus_state_t nxt_state;
   logic [pbus_pkg::CNT_W-1:0] cnt_ff;
   logic [pbus_pkg::CNT_W-1:0] nxt_cnt;
   logic [7:0] last_status_ff;
   logic [7:0] status_out_ff;
   logic busy_ff;

   // Status as sent includes the busy mirror, so a busy change is fresh status too.
   logic [7:0] status_now;
   always_comb
   begin
      status_now = status_in;
      status_now[pbus_pkg::BUSY_STATUS_BIT] = busy_ff;
   end
   wire status_fresh = (status_now != last_status_ff);
   wire cnt_done = (cnt_ff == 8'h00);
   // A peripheral write in flight owns the bus; do not drive over it.
   // The synchronised copy lags the pin by two cycles, a limit the writer must allow for.
   wire writer_active = ~wstrb_sync_ff[1];

   // Read requests are honoured first when not busy, then fresh status when no write strobe is in flight.
   always_comb
   begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      unique case (state_ff)
         ST_IDLE:
         begin
            if (read_req && !busy_ff)
            begin
               nxt_state = ST_READ;
               nxt_cnt = RD_CYC[7:0] - 8'h01;
            end
            else if (status_fresh && !writer_active)
            begin
               nxt_state = ST_STAT;
               nxt_cnt = STS_CYC[7:0] - 8'h01;
            end
         end
         ST_READ:
         begin
            if (cnt_done)
               nxt_state = ST_IDLE;
            else
               nxt_cnt = cnt_ff - 8'h01;
         end
         ST_STAT:
         begin
            if (cnt_done)
               nxt_state = ST_IDLE;
            else
               nxt_cnt = cnt_ff - 8'h01;
         end
      endcase
   end

   wire enter_stat = (state_ff == ST_IDLE) && (nxt_state == ST_STAT);
   // Sample the peripheral's byte on the last cycle the read strobe is low.
   wire read_take = (state_ff == ST_READ) && cnt_done;

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_ff <= ST_IDLE;
         cnt_ff <= 8'h00;
      end
      else
      begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
      end
   end

   // The sent byte is frozen for the whole strobe so the reader sees a stable value.
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         last_status_ff <= pbus_pkg::STATUS_RST;
         status_out_ff <= pbus_pkg::STATUS_RST;
      end
      else if (enter_stat)
      begin
         last_status_ff <= status_now;
         status_out_ff <= status_now;
      end
   end

   // =====================================================================
   // Busy handshake
   // =====================================================================
   logic [pbus_pkg::CNT_W-1:0] ack_cnt_ff;
   wire any_write = wr_if.valid | read_take;
   // Busy covers the acknowledge pulse and any time the buffer is full.
   wire nxt_busy = any_write | (ack_cnt_ff > 8'h01) | buffer_full;
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ack_cnt_ff <= 8'h00;
         busy_ff <= 1'b0;
      end
      else
      begin
         if (any_write)
            ack_cnt_ff <= ACK_CYC[7:0];
         else if (ack_cnt_ff != 8'h00)
            ack_cnt_ff <= ack_cnt_ff - 8'h01;
         busy_ff <= nxt_busy;
      end
   end

   // =====================================================================
   // Received byte output
   // =====================================================================
   logic rx_valid_ff;
   logic [7:0] rx_data_ff;
   logic rx_from_read_ff;
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rx_valid_ff <= 1'b0;
         rx_data_ff <= 8'h00;
         rx_from_read_ff <= 1'b0;
      end
      else
      begin
         rx_valid_ff <= any_write;
         if (wr_if.valid)
            rx_data_ff <= wr_if.data;
         else if (read_take)
            rx_data_ff <= bus_s2_ff;
         rx_from_read_ff <= read_take;
      end
   end

   // =====================================================================
   // Pin drive
   // =====================================================================
   assign rx_valid = rx_valid_ff;
   assign rx_data = rx_data_ff;
   assign rx_from_read = rx_from_read_ff;
   assign periph_read_strobe_n = ~(state_ff == ST_READ);
   assign status_strobe_n = ~(state_ff == ST_STAT);
   assign periph_byte_bus_oe = (state_ff == ST_STAT);
   assign periph_byte_bus_out = status_out_ff;
   assign busy_n_pin = busy_ff;
endmodule
`default_nettype wire

// ==== verif/pbus_asserts.sv ====
// Checker of the byte bus port, bound to its top module.
`default_nettype none
module pbus_asserts
#(
   parameter int unsigned ACK_CYC = 20
)
(
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // Watched ports
   input wire logic [7:0] periph_byte_bus_out,
   input wire logic periph_byte_bus_oe,
   input wire logic status_strobe_n,
   input wire logic periph_read_strobe_n,
   input wire logic periph_write_strobe_n,
   input wire logic busy_n_pin,
   input wire logic rx_valid,
   input wire logic rx_from_read,
   input wire logic buffer_full
);
   timeunit 1ns / 1ps;
   // ====
   // Busy length counter.
   logic [7:0] busy_cnt_ff;
   wire logic [7:0] nxt_busy_cnt = busy_n_pin ? busy_cnt_ff + 8'h01 : 8'h00;
   always_ff @(posedge mclk or negedge reset_n)
   begin
      if (!reset_n)
         busy_cnt_ff <= 8'h00;
      else
         busy_cnt_ff <= nxt_busy_cnt;
   end
   default clocking @(posedge mclk);
   endclocking
   default disable iff (!reset_n);
   // A write is acknowledged by a received byte with busy raised.
   sequence wr_done;
      $rose(periph_write_strobe_n);
   endsequence
   sequence byte_ack;
      rx_valid && busy_n_pin;
   endsequence
   oe_sts_a: assert property (periph_byte_bus_oe == !status_strobe_n)
      else $error("bus drive off strobe");
   one_strobe_a: assert property (status_strobe_n || periph_read_strobe_n)
      else $error("both strobes low");
   sts_mirror_a: assert property ($fell(status_strobe_n) |->
      periph_byte_bus_out[4] == $past(busy_n_pin) || periph_byte_bus_out[4] == $past(busy_n_pin, 2))
      else $error("busy bit not mirrored");
   wr_ack_a: assert property (wr_done |-> ##[1:6] byte_ack)
      else $error("write not acknowledged");
   rd_ack_a: assert property ($rose(periph_read_strobe_n) |-> ##[0:2] (rx_valid && rx_from_read))
      else $error("read byte not passed on");
   ack_len_a: assert property ($fell(busy_n_pin) |-> busy_cnt_ff >= ACK_CYC)
      else $error("busy pulse too short");
   full_hold_a: assert property (busy_n_pin && buffer_full |=> busy_n_pin)
      else $error("busy dropped while full");
   rx_pulse_a: assert property (rx_valid |=> !rx_valid)
      else $error("byte delivered twice");
endmodule
bind periph_byte_bus_port pbus_asserts #(.ACK_CYC(ACK_CYC)) pbus_asserts_i (.mclk, .reset_n,
   .periph_byte_bus_out, .periph_byte_bus_oe, .status_strobe_n, .periph_read_strobe_n,
   .periph_write_strobe_n, .busy_n_pin, .rx_valid, .rx_from_read, .buffer_full);
`default_nettype wire

// ==== verif/pbus_peer.sv ====
// Behavioural peripheral on the byte bus.
`default_nettype none
module pbus_peer
(
   // Clock and device pins
   input wire logic mclk,
   input wire logic busy_n_pin,
   input wire logic periph_read_strobe_n,
   // Byte given on read strobes
   input wire logic [7:0] rd_byte,
   // Peer drive
   output logic [7:0] drv,
   output logic periph_write_strobe_n
);
   timeunit 1ns / 1ps;
   // ====
   // Off a strobe the peer shows the inverse of its last byte, so a late sample is caught.
   logic [7:0] wr_val = 8'h5A;
   initial periph_write_strobe_n = 1'b1;
   assign drv = !periph_read_strobe_n ? rd_byte : wr_val;
   // Waits for busy low, then holds data four cycles past the strobe's rise.
   task write_byte(input logic [7:0] d);
      for (int i = 0; i < 200 && busy_n_pin; i++)
         @(posedge mclk);
      @(posedge mclk);
      wr_val <= d;
      periph_write_strobe_n <= 1'b0;
      repeat (3) @(posedge mclk);
      periph_write_strobe_n <= 1'b1;
      repeat (4) @(posedge mclk);
      wr_val <= ~d;
   endtask
endmodule
`default_nettype wire

// ==== verif/tb.sv ====
// Self-checking bench of the byte bus port.
`default_nettype none
module tb;
   timeunit 1ns / 1ps;
   // ====
   logic mclk = 1'b0;
   logic reset_n = 1'b0;
   logic buffer_full = 1'b0;
   logic read_req = 1'b0;
   logic [7:0] status_in = 8'h00;
   logic [7:0] rd_byte = 8'h96;
   logic [7:0] periph_byte_bus_out, drv, rx_data, sts_byte = 8'h00, sts_cnt = 8'h00;
   logic [8:0] rx_got = 9'h000;
   logic periph_byte_bus_oe, status_strobe_n, periph_read_strobe_n, periph_write_strobe_n, busy_n_pin;
   logic rx_valid, rx_from_read, sts_q = 1'b1, sts_hi = 1'b0;
   int error_cnt = 0;
   int cmp_count = 0;
   wire logic [7:0] bus = periph_byte_bus_oe ? periph_byte_bus_out : drv;
   // Clock at 200 MHz.
   initial forever #2.5 mclk = ~mclk;
   periph_byte_bus_port #(.ACK_CYC(4), .RD_CYC(4), .STS_CYC(1)) periph_byte_bus_port_i (.mclk, .reset_n,
      .periph_byte_bus_in(bus), .periph_byte_bus_out, .periph_byte_bus_oe, .status_strobe_n,
      .periph_read_strobe_n, .periph_write_strobe_n, .busy_n_pin, .rx_valid, .rx_data, .rx_from_read,
      .buffer_full, .read_req, .status_in);
   pbus_peer pbus_peer_i (.mclk, .busy_n_pin, .periph_read_strobe_n, .rd_byte, .drv, .periph_write_strobe_n);
   // Records status strobes and received bytes at the falling edge, where all is settled.
   always @(negedge mclk)
   begin
      sts_q <= status_strobe_n;
      if (sts_q && !status_strobe_n)
      begin
         sts_cnt <= sts_cnt + 8'h01;
         sts_byte <= bus;
         sts_hi <= sts_hi | bus[4];
      end
      if (rx_valid === 1'b1)
         rx_got <= {rx_from_read, rx_data};
   end
   task chk(input logic [8:0] got, input logic [8:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task report_and_stop();
      $display("compares %0d errors %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic wait_on(ref logic s, input logic v);
      int n;
      for (n = 0; n < 100 && s !== v; n++)
         @(negedge mclk);
      if (s !== v)
      begin
         error_cnt++;
         $display("ERROR %0t: wait ran out", $time);
         report_and_stop();
      end
   endtask
   task do_write(input logic [7:0] d);
      fork
         pbus_peer_i.write_byte(d);
         wait_on(rx_valid, 1'b1);
      join
      // The recorder updates on the same edge the wait returns on, so let it settle.
      @(posedge mclk);
      chk(rx_got, {1'b0, d});
   endtask
   // A changed status strobes once; a change hidden under the busy bit does not.
   task t_status();
      @(posedge mclk) status_in <= 8'h2A;
      repeat (30) @(negedge mclk);
      chk({1'b0, sts_byte}, 9'h02A);
      @(posedge mclk) status_in <= 8'h3A;
      repeat (30) @(negedge mclk);
      chk({1'b0, sts_cnt}, 9'h001);
   endtask
   task t_write();
      do_write(8'hC3);
      do_write(8'h3C);
      wait_on(busy_n_pin, 1'b0);
      chk({8'h00, sts_hi}, 9'h001);
   endtask
   // The write itself fills the buffer, so full is raised while its acknowledge still stands.
   task t_full();
      fork
         pbus_peer_i.write_byte(8'hF0);
         begin
            wait_on(rx_valid, 1'b1);
            @(posedge mclk) buffer_full <= 1'b1;
         end
      join
      chk(rx_got, 9'h0F0);
      repeat (20) @(negedge mclk);
      chk({8'h00, busy_n_pin}, 9'h001);
      @(posedge mclk) buffer_full <= 1'b0;
      wait_on(busy_n_pin, 1'b0);
   endtask
   task t_read();
      @(posedge mclk) read_req <= 1'b1;
      wait_on(rx_valid, 1'b1);
      @(posedge mclk) read_req <= 1'b0;
      chk(rx_got, 9'h196);
      wait_on(busy_n_pin, 1'b0);
   endtask
   initial
   begin
      repeat (16) @(posedge mclk);
      reset_n <= 1'b1;
      repeat (4) @(posedge mclk);
      t_status();
      t_write();
      t_full();
      t_read();
      report_and_stop();
   end
endmodule
`default_nettype wire
